// ===== media_ctrl_consts.vh
// constants for the media converter fault and loopback control block
`ifndef MEDIA_CTRL_CONSTS_VH
`define MEDIA_CTRL_CONSTS_VH

// register word offsets (one address per 32-bit register)
`define REG_PORT_CFG    4'h0
`define REG_FAULT_CFG   4'h1
`define REG_LOOP_CFG    4'h2
`define REG_BW_C2F      4'h3
`define REG_BW_F2C      4'h4
`define REG_STATUS      4'h5

// port_cfg fields
`define PC_AUTONEG      0
`define PC_SPEED100     1
`define PC_FULL_DUPLEX  2
`define PC_SEL_ADV      3
`define PC_FIBER_FORCED 4
`define PORT_CFG_RESET  5'h01

// fault_cfg fields
`define FC_FIBER_FWD    0
`define FC_COPPER_FWD   1
`define FC_REFLECT      2
`define FC_PEER_PASS    3

// loop_cfg fields
`define LC_ENABLE       0
`define LC_SWAP         1
`define LC_CLEAR_MC     2

// status fields
`define ST_COPPER_LINK  0
`define ST_FIBER_LINK   1
`define ST_PASS_ACTIVE  2
`define ST_MDIX         3
`define ST_ROLE_LO      4
`define ST_SPEED_LO     6

// speed codes
`define SPD_10          2'h0
`define SPD_100         2'h1
`define SPD_1000        2'h2

// limiter step in units of 10 bit/s
`define STEP_10M        32'h0000_01E8
`define STEP_100M       32'h0000_1310
`define STEP_1000M      32'h0000_5F50

// roles
`define ROLE_STANDALONE 2'h0
`define ROLE_REMOTE     2'h1
`define ROLE_HOST       2'h2

// timing: clock rate and rate window
`define CLK_HZ          20000000
`define WINDOW_CYC      32'd20000000

`endif

// ===== media_fault_loop_ctrl.v
// fault forwarding, loopback rewrite and bandwidth limit control
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "media_ctrl_consts.vh"

module media_fault_loop_ctrl
#(
  parameter WINDOW_CYC = `WINDOW_CYC
)
(
  input  wire        clk,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // straps, sampled after reset release
  input  wire        strap_host,
  input  wire        strap_remote,
  // link signalling from the phys
  input  wire        copper_link_ok,
  input  wire [1:0]  copper_speed,
  input  wire        copper_pair_swapped,
  input  wire        fiber_link_ok,
  input  wire        fiber_rx_fault,
  input  wire        peer_pass_enabled,
  // phy control
  output reg         copper_enable,
  output reg         fiber_tx_enable,
  output reg         copper_autoneg,
  output reg  [3:0]  copper_adv,
  output reg         copper_mdix,
  output reg         fiber_autoneg_mode,
  output reg         copper_link_led,
  output reg         fiber_link_led,
  // frame byte stream from the uplink toward the loop
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  input  wire        rx_sof,
  input  wire        rx_is_mgmt,
  input  wire        rx_from_copper,
  output reg  [7:0]  tx_data,
  output reg         tx_valid,
  output reg         tx_loop,
  output reg         tx_drop,
  output reg         mgmt_valid,
  output reg  [7:0]  mgmt_data
);

  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rs_n = rst_sync_r;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [4:0]  port_cfg_r;
  reg [3:0]  fault_cfg_r;
  reg [2:0]  loop_cfg_r;
  reg [15:0] bw_c2f_r;
  reg [15:0] bw_f2c_r;
  reg [1:0]  role_r;
  reg        role_done_r;

  // per-speed step in units of 10 bit/s
  function [31:0] step_of;
    input [1:0] spd;
    begin
      case (spd)
        `SPD_10:  step_of = `STEP_10M;
        `SPD_100: step_of = `STEP_100M;
        default:  step_of = `STEP_1000M;
      endcase
    end
  endfunction

  wire fiber_fwd  = fault_cfg_r[`FC_FIBER_FWD];
  wire copper_fwd = fault_cfg_r[`FC_COPPER_FWD];
  // pass-through needs both forwards here and at the peer
  wire pass_active = fiber_fwd & copper_fwd & peer_pass_enabled &
                     (role_r != `ROLE_STANDALONE);

  wire [31:0] status_word = {24'h000000, copper_speed,
                             role_r, copper_mdix, pass_active,
                             fiber_link_led, copper_link_led};

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_cfg_r      <= `PORT_CFG_RESET;
      fault_cfg_r     <= 4'h0;
      loop_cfg_r      <= 3'h0;
      bw_c2f_r        <= 16'h0000;
      bw_f2c_r        <= 16'h0000;
      role_r          <= `ROLE_STANDALONE;
      role_done_r     <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if (!rs_n)
    begin
      port_cfg_r      <= `PORT_CFG_RESET; // autoneg on both ports
      role_done_r     <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      if (!role_done_r)
      begin
        role_done_r <= 1'b1;
        // strap capture; both on is treated as host
        role_r <= strap_host ? `ROLE_HOST :
                  strap_remote ? `ROLE_REMOTE : `ROLE_STANDALONE;
      end
      // one wait cycle per access, answer on the second edge
      if ((avs_read | avs_write) & avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        if (avs_write)
        begin
          case (avs_address)
            `REG_PORT_CFG:  port_cfg_r  <= avs_writedata[4:0];
            `REG_FAULT_CFG: fault_cfg_r <= avs_writedata[3:0];
            `REG_LOOP_CFG:  loop_cfg_r  <= avs_writedata[2:0];
            `REG_BW_C2F:    bw_c2f_r    <= avs_writedata[15:0];
            `REG_BW_F2C:    bw_f2c_r    <= avs_writedata[15:0];
            default:        ;
          endcase
        end
        case (avs_address)
          `REG_PORT_CFG:  avs_readdata <= {27'h0, port_cfg_r};
          `REG_FAULT_CFG: avs_readdata <= {28'h0, fault_cfg_r};
          `REG_LOOP_CFG:  avs_readdata <= {29'h0, loop_cfg_r};
          `REG_BW_C2F:    avs_readdata <= {16'h0, bw_c2f_r};
          `REG_BW_F2C:    avs_readdata <= {16'h0, bw_f2c_r};
          `REG_STATUS:    avs_readdata <= status_word;
          default:        avs_readdata <= 32'h0000_0000;
        endcase
      end
      else
        avs_waitrequest <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // link, fault forwarding and port modes
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      copper_enable      <= 1'b1;
      fiber_tx_enable    <= 1'b1;
      copper_autoneg     <= 1'b1;
      copper_adv         <= 4'hF;
      copper_mdix        <= 1'b0;
      fiber_autoneg_mode <= 1'b1;
      copper_link_led    <= 1'b0;
      fiber_link_led     <= 1'b0;
    end
    else
    begin
      copper_link_led <= copper_link_ok;
      fiber_link_led  <= fiber_link_ok;
      // copper drops on fiber loss
      copper_enable <= ~((fiber_fwd | pass_active) & ~fiber_link_ok);
      // fiber drops on copper loss or reflected rx fault
      fiber_tx_enable <= ~(((copper_fwd | pass_active) & ~copper_link_ok)
                        | (fault_cfg_r[`FC_REFLECT] & fiber_rx_fault))
                        ;
      copper_autoneg <= port_cfg_r[`PC_AUTONEG];
      // adv bits: 10h,10f,100h,100f; selective offers one
      if (port_cfg_r[`PC_SEL_ADV])
        copper_adv <= 4'h1 << {port_cfg_r[`PC_SPEED100],
                               port_cfg_r[`PC_FULL_DUPLEX]};
      else
        copper_adv <= 4'hF;
      copper_mdix <= copper_pair_swapped;
      // fiber is fixed 1000 full; only the setup mode varies
      fiber_autoneg_mode <= ~port_cfg_r[`PC_FIBER_FORCED];
    end
  end

  // ---------------------------------------------------------------
  // bandwidth limiter: credit per window, equal for all frames
  // ---------------------------------------------------------------
  reg [31:0] win_cnt_r;
  reg [47:0] used_c2f_r;
  reg [47:0] used_f2c_r;
  wire [47:0] lim_c2f = bw_c2f_r * step_of(copper_speed);
  wire [47:0] lim_f2c = bw_f2c_r * step_of(copper_speed);
  // byte costs 80 units of 10 bit/s over a one-second window
  wire over_c2f = (bw_c2f_r != 16'h0) & (used_c2f_r >= lim_c2f);
  wire over_f2c = (bw_f2c_r != 16'h0) & (used_f2c_r >= lim_f2c);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_cnt_r  <= 32'h0000_0000;
      used_c2f_r <= 48'h0;
      used_f2c_r <= 48'h0;
    end
    else if (win_cnt_r >= WINDOW_CYC - 1)
    begin
      win_cnt_r  <= 32'h0000_0000;
      used_c2f_r <= 48'h0;
      used_f2c_r <= 48'h0;
    end
    else
    begin
      win_cnt_r <= win_cnt_r + 32'h1;
      // management bytes are charged like data
      if (rx_valid & rx_from_copper & ~over_c2f)
        used_c2f_r <= used_c2f_r + 48'h50;
      if (rx_valid & ~rx_from_copper & ~over_f2c)
        used_f2c_r <= used_f2c_r + 48'h50;
    end
  end

  // ---------------------------------------------------------------
  // loopback address rewrite: six-byte delay line
  // ---------------------------------------------------------------
  // the new destination is the old source, which arrives six bytes
  // later, so every byte toward tx waits six cycles; the rewrite
  // assumes the twelve address bytes arrive back to back
  localparam DLY = 6;
  localparam EW  = 12;
  wire [EW-1:0] ent_in = {rx_from_copper, rx_is_mgmt, rx_sof, rx_valid,
                          rx_data};
  wire [EW-1:0] dly_w [0:DLY];
  assign dly_w[0] = ent_in;

  genvar g;
  generate
    for (g = 0; g < DLY; g = g + 1)
    begin : g_dly
      reg [EW-1:0] stage_r;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          stage_r <= {EW{1'b0}};
        else
          stage_r <= dly_w[g];
      end
      assign dly_w[g+1] = stage_r;
    end
  endgenerate

  // byte leaving the delay line and its flags
  wire [7:0] o_data   = dly_w[DLY][7:0];
  wire       o_valid  = dly_w[DLY][8];
  wire       o_sof    = dly_w[DLY][9];
  wire       o_mgmt   = dly_w[DLY][10];
  wire       o_copper = dly_w[DLY][11];

  reg  [3:0] opos_r;
  reg  [7:0] hdr_r [0:5];
  wire [3:0] o_pos = o_sof ? 4'h0 : opos_r;
  wire [3:0] hsel  = o_pos - 4'h6;
  wire loop_on = loop_cfg_r[`LC_ENABLE] & (role_r != `ROLE_HOST);
  wire swap_on = loop_cfg_r[`LC_SWAP] | loop_cfg_r[`LC_CLEAR_MC];
  wire rewrite = loop_on & swap_on & ~o_mgmt & ~o_copper;
  wire o_over  = o_copper ? over_c2f : over_f2c;

  // header zone of a byte position: 0 dest, 1 source, 2 payload
  function [1:0] pos_zone;
    input [3:0] p;
    begin
      if (p < 4'h6)
        pos_zone = 2'h0;
      else if (p < 4'hC)
        pos_zone = 2'h1;
      else
        pos_zone = 2'h2;
    end
  endfunction

  reg [7:0] o_byte;
  always @*
  begin
    o_byte = o_data;
    if (rewrite)
    begin
      case (pos_zone(o_pos))
        2'h0:
        begin
          // source byte arriving now becomes the destination
          o_byte = rx_data;
          if (o_pos == 4'h0 && loop_cfg_r[`LC_CLEAR_MC])
            o_byte = rx_data & 8'hFE;
        end
        2'h1:    o_byte = hdr_r[hsel[2:0]];
        default: o_byte = o_data;
      endcase
    end
  end

  integer k;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opos_r     <= 4'h0;
      tx_data    <= 8'h00;
      tx_valid   <= 1'b0;
      tx_loop    <= 1'b0;
      tx_drop    <= 1'b0;
      mgmt_valid <= 1'b0;
      mgmt_data  <= 8'h00;
      for (k = 0; k < 6; k = k + 1)
        hdr_r[k] <= 8'h00;
    end
    else
    begin
      // management from uplink goes to the agent, never looped
      mgmt_valid <= rx_valid & rx_is_mgmt;
      mgmt_data  <= rx_data;
      tx_drop    <= o_valid & o_over;
      tx_loop    <= loop_on & ~o_mgmt & ~o_copper;
      tx_valid   <= o_valid & ~o_over & ~(o_mgmt & loop_on);
      tx_data    <= o_byte;
      if (o_valid)
      begin
        if (o_sof)
          opos_r <= 4'h1;
        else if (opos_r != 4'hC)
          opos_r <= opos_r + 4'h1;
        // keep the old destination for the source slots
        if (pos_zone(o_pos) == 2'h0)
          hdr_r[o_pos[2:0]] <= o_data;
      end
    end
  end

endmodule // media_fault_loop_ctrl
`default_nettype wire

// ===== media_ctrl_checker_assertions.sv
// checker for bus, link, fault and loopback relations
`timescale 1ns/1ps
`default_nettype none
`include "media_ctrl_consts.vh"
module media_ctrl_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        copper_link_ok,
  input wire logic        fiber_link_ok,
  input wire logic        fiber_rx_fault,
  input wire logic        copper_enable,
  input wire logic        fiber_tx_enable,
  input wire logic        copper_link_led,
  input wire logic        fiber_link_led,
  input wire logic        rx_valid,
  input wire logic        rx_is_mgmt,
  input wire logic        tx_valid,
  input wire logic        tx_loop
);
  logic [2:0] fault_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  // shadow of the fault setup: a write counts only at its ack edge
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      fault_r <= 3'h0;
    else if (avs_write && !avs_waitrequest &&
             avs_address == `REG_FAULT_CFG)
      fault_r <= avs_writedata[2:0];
  a_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus answer is not a one cycle pulse");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address > `REG_STATUS |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_copper_led: assert property (!copper_link_ok |=> !copper_link_led)
    else $error("copper led on without link");
  a_fiber_led: assert property (!fiber_link_ok |=> !fiber_link_led)
    else $error("fiber led on without link");
  a_fiber_fwd: assert property (fault_r[0] && !fiber_link_ok |=> !copper_enable)
    else $error("fiber fault not forwarded");
  a_copper_fwd: assert property (fault_r[1] && !copper_link_ok |=> !fiber_tx_enable)
    else $error("copper fault not forwarded");
  a_fault_reflect: assert property (fault_r[2] && fiber_rx_fault |=> !fiber_tx_enable)
    else $error("fiber fault not reflected");
  a_mgmt_kept: assert property (rx_valid && rx_is_mgmt |-> ##7 !(tx_valid && tx_loop))
    else $error("management byte looped back");
endmodule // media_ctrl_checker
bind media_fault_loop_ctrl media_ctrl_checker media_ctrl_checker_i (.*);
`default_nettype wire

// ===== link_partner_model.sv
// far side model: copper partner and paired fiber peer
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
  input  wire logic clk,
  input  wire logic copper_enable,
  input  wire logic cu_cable_ok,
  input  wire logic fib_cable_ok,
  input  wire logic peer_forwards,
  output var logic  copper_link_ok,
  output var logic  fiber_link_ok,
  output var logic  fiber_rx_fault,
  output var logic  peer_pass_enabled
);
  // the peer never reflects faults, so a pair cannot lock up
  initial
  begin
    copper_link_ok    = 1'b0;
    fiber_link_ok     = 1'b0;
    fiber_rx_fault    = 1'b0;
    peer_pass_enabled = 1'b0;
  end
  always @(posedge clk)
  begin
    copper_link_ok    <= cu_cable_ok && copper_enable;
    fiber_link_ok     <= fib_cable_ok;
    fiber_rx_fault    <= !fib_cable_ok;
    peer_pass_enabled <= peer_forwards;
  end
endmodule // link_partner_model
`default_nettype wire

// ===== media_fault_loop_ctrl_bench.sv
// bench: bus, port setup, fault forwarding and loopback cases
`timescale 1ns/1ps
`default_nettype none
`include "media_ctrl_consts.vh"
module media_fault_loop_ctrl_bench;
  logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0, copper_adv;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, cu_ok = 1'b1, fib_ok = 1'b1, peer = 1'b0;
  logic        copper_link_ok, fiber_link_ok, fiber_rx_fault;
  logic        peer_pass_enabled, copper_enable, fiber_tx_enable;
  logic        copper_autoneg, fiber_autoneg_mode, copper_link_led;
  logic        fiber_link_led, tx_valid, tx_loop, mgmt_valid;
  logic [7:0]  rx_data = 8'h0, tx_data;
  logic        rx_valid = 1'b0, rx_sof = 1'b0, rx_is_mgmt = 1'b0;
  logic [7:0]  got[$];
  logic        strap_rm = 1'b1, pair_sw = 1'b0, copper_mdix;
  int          n_mismatch = 0, num_checks = 0, n_mgmt = 0;
  // ----
  // design, far side and capture
  // ----
  media_fault_loop_ctrl #(.WINDOW_CYC(100)) media_fault_loop_ctrl_i (
    .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .strap_host(1'b0),
    .strap_remote(strap_rm), .copper_link_ok, .copper_speed(2'h1),
    .copper_pair_swapped(pair_sw), .fiber_link_ok, .fiber_rx_fault,
    .peer_pass_enabled, .copper_enable, .fiber_tx_enable,
    .copper_autoneg, .copper_adv, .copper_mdix, .fiber_autoneg_mode,
    .copper_link_led, .fiber_link_led, .rx_data, .rx_valid, .rx_sof,
    .rx_is_mgmt, .rx_from_copper(1'b0), .tx_data, .tx_valid, .tx_loop,
    .tx_drop(), .mgmt_valid, .mgmt_data());
  link_partner_model link_partner_model_i (.clk, .copper_enable,
    .cu_cable_ok(cu_ok), .fib_cable_ok(fib_ok), .peer_forwards(peer),
    .copper_link_ok, .fiber_link_ok, .fiber_rx_fault, .peer_pass_enabled);
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_loop === 1'b1)
      got.push_back(tx_data);
    if (mgmt_valid === 1'b1)
      n_mgmt++;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one idle edge at the end keeps back to back calls from
  // assigning the strobes twice in one time step
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask
  task t_regs;
    bus(1'b0, `REG_PORT_CFG, 32'h0);
    chk("port_cfg", `PORT_CFG_RESET, q);
    chk("autoneg", 2'h3, {copper_autoneg, fiber_autoneg_mode});
    bus(1'b1, 4'hF, 32'hFF);
    bus(1'b0, 4'hF, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, `REG_BW_C2F, 32'h5);
    bus(1'b1, `REG_BW_F2C, 32'h9);
    bus(1'b0, `REG_BW_C2F, 32'h0);
    chk("bw_c2f", 32'h5, q);
    bus(1'b0, `REG_BW_F2C, 32'h0);
    chk("bw_f2c", 32'h9, q);
  endtask
  task t_port;
    logic [3:0] acc;
    acc = 4'h0;
    bus(1'b1, `REG_PORT_CFG, 32'h6);
    cyc(2);
    chk("forced autoneg", 1'b0, copper_autoneg);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, `REG_PORT_CFG, 32'h9 | (i << 1));
      cyc(2);
      chk("adv one", 32'h1, $countones(copper_adv));
      acc = acc | copper_adv;
    end
    chk("adv all", 4'hF, acc);
    bus(1'b1, `REG_PORT_CFG, 32'h11);
    cyc(2);
    chk("fiber autoneg", 1'b0, fiber_autoneg_mode);
    pair_sw <= 1'b1;
    cyc(3);
    chk("mdix on", 1'b1, copper_mdix);
    pair_sw <= 1'b0;
    cyc(3);
    chk("mdix off", 1'b0, copper_mdix);
  endtask
  task fcase(input logic [31:0] cfg, input logic cu, fb, ecu, efb);
    bus(1'b1, `REG_FAULT_CFG, cfg);
    cu_ok  <= cu;
    fib_ok <= fb;
    cyc(6);
    chk("copper_enable", ecu, copper_enable);
    chk("fiber_tx_enable", efb, fiber_tx_enable);
    chk("fiber led", fb, fiber_link_led);
    cu_ok  <= 1'b1;
    fib_ok <= 1'b1;
    cyc(8);
  endtask
  task t_pass;
    peer <= 1'b1;
    fcase(32'h3, 1'b0, 1'b1, 1'b1, 1'b0);
    fcase(32'h3, 1'b1, 1'b0, 1'b0, 1'b0);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("pass on", 1'b1, q[`ST_PASS_ACTIVE]);
    peer <= 1'b0;
    cyc(3);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("pass off", 1'b0, q[`ST_PASS_ACTIVE]);
  endtask
  // destination 10..15, source 21..26: first source octet is group
  function automatic logic [7:0] fb_byte(input int i);
    if (i < 6)
      return 8'h10 + i[7:0];
    if (i < 12)
      return 8'h1B + i[7:0];
    return 8'hC0 + i[7:0];
  endfunction
  task frame(input logic [31:0] mode);
    int j;
    logic [7:0] e;
    bus(1'b1, `REG_LOOP_CFG, mode);
    got.delete();
    for (int i = 0; i < 16; i++)
    begin
      rx_valid <= 1'b1;
      rx_sof   <= (i == 0);
      rx_data  <= fb_byte(i);
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_sof   <= 1'b0;
    cyc(10);
    chk("loop length", 32'h10, got.size());
    for (int i = 0; i < 16; i++)
    begin
      j = (!mode[1] || i > 11) ? i : (i < 6 ? i + 6 : i - 6);
      e = fb_byte(j);
      if (i == 0 && mode[2])
        e[0] = 1'b0;
      chk("loop byte", e, got[i]);
    end
  endtask
  task t_mgmt;
    got.delete();
    n_mgmt = 0;
    rx_valid   <= 1'b1;
    rx_sof     <= 1'b1;
    rx_is_mgmt <= 1'b1;
    rx_data    <= 8'h5A;
    @(posedge clk);
    rx_valid   <= 1'b0;
    rx_sof     <= 1'b0;
    rx_is_mgmt <= 1'b0;
    cyc(10);
    chk("mgmt taken", 32'h1, n_mgmt);
    chk("mgmt looped", 32'h0, got.size());
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    t_regs;
    t_port;
    fcase(32'h0, 1'b1, 1'b0, 1'b1, 1'b1);
    fcase(32'h1, 1'b1, 1'b0, 1'b0, 1'b1);
    fcase(32'h2, 1'b0, 1'b1, 1'b1, 1'b0);
    fcase(32'h4, 1'b1, 1'b0, 1'b1, 1'b0);
    t_pass;
    frame(32'h1);
    frame(32'h3);
    frame(32'h7);
    t_mgmt;
    finish_test;
  end
endmodule // media_fault_loop_ctrl_bench
`default_nettype wire
